// >>> verilog/drs_consts.svh
// constants for the result status byte encoder
// Operation
// - result bytes leave one by one through data port
// - byte 0 bits 7:6 hold termination class
// - byte 0 bit 5 flags finished head positioning
// - byte 0 bit 4: home missing after 80 steps
// - byte 0 bit 4: relative seek passes outermost track
// - byte 0: bit3 zero, head, drive number
// - byte 1 bit 7: past last sector, no count-end
// - byte 1 bit 5 CRC fault; bits 6,3 zero
// - byte 1 bit 4 flags overrun or underrun
// - byte 1 bit 2 flags sector not found
// - byte 1 bit 1: protect high during write
// - byte 1 bit 0: address mark not found
// - byte 2 bit 6 wrong mark kind; 7,3,2 zero
// - byte 2 bit 5 flags data field CRC
// - byte 2 bit 4 flags track number mismatch
// - byte 2 bit 0 flags missing data mark
// - byte 3 shows live protect and home inputs
// - byte 3 shows side and unit select pins
// - byte 3: bit7 zero, bits 5,3 one
`ifndef DRS_CONSTS_SVH
`define DRS_CONSTS_SVH

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define DRS_ST0_CLASS_HI     7
`define DRS_ST0_CLASS_LO     6
`define DRS_ST0_POS_DONE     5
`define DRS_ST0_HOME_FAULT   4
`define DRS_ST0_ZERO         3
`define DRS_ST0_HEAD         2
`define DRS_ST0_UNIT_HI      1
`define DRS_ST0_UNIT_LO      0
`define DRS_ST1_END_TRACK    7
`define DRS_ST1_ZERO_HI      6
`define DRS_ST1_CRC_ANY      5
`define DRS_ST1_OVERRUN      4
`define DRS_ST1_ZERO_LO      3
`define DRS_ST1_SECT_MISS    2
`define DRS_ST1_WR_BLOCK     1
`define DRS_ST1_ID_SYNC      0
`define DRS_ST2_ZERO_HI      7
`define DRS_ST2_CTRL_MARK    6
`define DRS_ST2_DATA_CRC     5
`define DRS_ST2_TRK_MISM     4
`define DRS_ST2_ZERO_MID     3
`define DRS_ST2_ZERO_LO      2
`define DRS_ST2_BAD_TRK      1
`define DRS_ST2_DATA_SYNC    0
`define DRS_ST3_ZERO         7
`define DRS_ST3_WP           6
`define DRS_ST3_ONE_HI       5
`define DRS_ST3_HOME         4
`define DRS_ST3_ONE_LO       3
`define DRS_ST3_SIDE         2

// ----------------------------------------------------------------
// values and counts
// ----------------------------------------------------------------
`define DRS_BYTE_ZERO        8'h00
`define DRS_BAD_TRACK        8'hFF
`define DRS_RECAL_STEPS      7'h50
`define DRS_INDEX_LIMIT      2'h2
`define DRS_IDX_ZERO         2'h0
`define DRS_IDX_ONE          2'h1
`define DRS_CNT_XFER         2'h3
`define DRS_CNT_ONE          2'h1

`endif

// >>> verilog/drs_pkg.sv
// types shared by the result status byte encoder
`default_nettype none
package drs_pkg;
  typedef enum logic [1:0] {
    DRS_TC_NORMAL  = 2'h0,
    DRS_TC_ABORT   = 2'h1,
    DRS_TC_INVALID = 2'h2,
    DRS_TC_POLL    = 2'h3
  } drs_class_e;

  typedef enum logic [3:0] {
    DRS_CMD_READ, DRS_CMD_READ_DEL, DRS_CMD_WRITE, DRS_CMD_WRITE_DEL, DRS_CMD_FORMAT,
    DRS_CMD_READ_ID, DRS_CMD_READ_TRACK, DRS_CMD_RECAL, DRS_CMD_SEEK, DRS_CMD_REL_SEEK,
    DRS_CMD_SENSE_INT, DRS_CMD_SENSE_DRV, DRS_CMD_INVALID, DRS_CMD_OTHER
  } drs_cmd_e;

  typedef enum logic [1:0] {
    DRS_ST_IDLE,
    DRS_ST_EXEC,
    DRS_ST_RESULT
  } drs_state_e;
endpackage : drs_pkg
`default_nettype wire

// >>> verilog/drs_seek_check.sv
// recalibrate step watch and relative seek range check
`include "drs_consts.svh"
`timescale 1ns/1ps
`default_nettype none
module drs_seek_check
(
  input  wire logic       core_clk,
  input  wire logic       rst,
  input  wire logic       recal_start,
  input  wire logic       step_pulse,
  input  wire logic       home_track_in,
  input  wire logic       relseek_start,
  input  wire logic       seek_outward,
  input  wire logic [7:0] seek_distance,
  input  wire logic [7:0] internal_track,
  output logic            fault_q
);
  logic       active_q;
  logic [6:0] steps_q;

  // ----------------------------------------------------------------
  // step counter while recalibrating
  // ----------------------------------------------------------------
  // counting stops at home or at the limit, so a slow drive never wraps the count
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      active_q <= 1'b0;
      steps_q  <= 7'h00;
    end
    else if (recal_start)
    begin
      active_q <= 1'b1;
      steps_q  <= 7'h00;
    end
    else if (active_q && (home_track_in || steps_q == `DRS_RECAL_STEPS))
      active_q <= 1'b0;
    else if (active_q && step_pulse)
      steps_q <= steps_q + 7'h01;
  end

  // fault is a one-cycle pulse; the caller keeps it sticky
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
      fault_q <= 1'b0;
    else
      fault_q <= (active_q && !home_track_in && steps_q == `DRS_RECAL_STEPS)
              || (relseek_start && seek_outward && seek_distance > internal_track);
  end

  property p_home_fault;
    @(posedge core_clk) disable iff (rst)
    active_q && !home_track_in && steps_q == `DRS_RECAL_STEPS && !recal_start |=> fault_q ##1 !active_q;
  endproperty
  a_home_fault: assert property (p_home_fault) else $error("home fault not raised");

  property p_relseek_fault;
    @(posedge core_clk) disable iff (rst)
    relseek_start && seek_outward && (seek_distance > internal_track) |=> fault_q;
  endproperty
  a_relseek_fault: assert property (p_relseek_fault) else $error("outward seek fault missed");
endmodule : drs_seek_check
`default_nettype wire

// >>> verilog/drs_result_status.sv
// result status byte encoder and result phase read sequencer
`include "drs_consts.svh"
`timescale 1ns/1ps
`default_nettype none
module drs_result_status
(
  input  wire logic             core_clk,
  input  wire logic             rst,
  input  wire logic             exec_start,
  input  wire drs_pkg::drs_cmd_e cmd_kind,
  input  wire logic             cmd_done,
  input  wire drs_pkg::drs_class_e done_class,
  input  wire logic             head_addr,
  input  wire logic [1:0]       drive_sel,
  input  wire logic             step_pulse,
  input  wire logic             home_track_in,
  input  wire logic             seek_outward,
  input  wire logic [7:0]       seek_distance,
  input  wire logic [7:0]       internal_track,
  input  wire logic             transfer_count_end,
  input  wire logic             sector_beyond,
  input  wire logic             crc_id_err,
  input  wire logic             crc_data_err,
  input  wire logic             xfer_overrun,
  input  wire logic             sector_not_found,
  input  wire logic             wp_in,
  input  wire logic             rotation_marker_in,
  input  wire logic             id_mark_found,
  input  wire logic             data_mark_found,
  input  wire logic             data_mark_deleted,
  input  wire logic             data_mark_missing,
  input  wire logic             id_valid,
  input  wire logic [7:0]       id_track,
  input  wire logic             side_select_out,
  input  wire logic [1:0]       unit_select,
  input  wire logic             host_rd,
  output logic [7:0]            result_data_q,
  output logic                  host_service_request_q,
  output logic                  transfer_direction_q,
  output logic                  result_phase_q
);
  import drs_pkg::*;

  drs_state_e state_q;
  drs_cmd_e   cmd_q;
  logic       tc_seen_q, end_track_q, crc_any_q, overrun_q, sect_miss_q, wr_block_q, id_sync_q;
  logic       ctrl_mark_q, data_crc_q, trk_mism_q, bad_trk_q, data_sync_q;
  logic       pos_done_q, home_fault_q, seek_fault;
  logic [1:0] index_cnt_q;
  logic [7:0] st0_q, st1_q, st2_q, st3_q;
  logic [1:0] res_cnt_q, res_idx_q;
  logic       is_write, is_read_data, seek_cmd, last_rd;

  // ----------------------------------------------------------------
  // command decode
  // ----------------------------------------------------------------
  function automatic logic fn_is_write(input drs_cmd_e c);
    fn_is_write = (c == DRS_CMD_WRITE) || (c == DRS_CMD_WRITE_DEL) || (c == DRS_CMD_FORMAT);
  endfunction : fn_is_write

  function automatic logic fn_is_rw(input drs_cmd_e c);
    fn_is_rw = (c == DRS_CMD_READ) || (c == DRS_CMD_READ_DEL)
            || (c == DRS_CMD_WRITE) || (c == DRS_CMD_WRITE_DEL);
  endfunction : fn_is_rw

  assign is_write     = fn_is_write(cmd_q);
  assign is_read_data = (cmd_q == DRS_CMD_READ) || (cmd_q == DRS_CMD_READ_DEL);
  assign seek_cmd     = (cmd_q == DRS_CMD_SEEK) || (cmd_q == DRS_CMD_REL_SEEK) || (cmd_q == DRS_CMD_RECAL);
  assign last_rd      = host_rd && (state_q == DRS_ST_RESULT) && (res_idx_q == res_cnt_q - `DRS_IDX_ONE);

  // ----------------------------------------------------------------
  // phase sequencer
  // ----------------------------------------------------------------
  // positioning commands return no bytes; their outcome waits for sense-interrupt
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      state_q <= DRS_ST_IDLE;
      cmd_q   <= DRS_CMD_OTHER;
    end
    else
    begin
      unique case (state_q)
        DRS_ST_IDLE:
        begin
          if (exec_start)
          begin
            state_q <= DRS_ST_EXEC;
            cmd_q   <= cmd_kind;
          end
        end
        DRS_ST_EXEC:
        begin
          if (cmd_done)
            state_q <= (seek_cmd || cmd_q == DRS_CMD_OTHER) ? DRS_ST_IDLE : DRS_ST_RESULT;
        end
        DRS_ST_RESULT:
        begin
          if (last_rd)
            state_q <= DRS_ST_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // error flags gathered during execution
  // ----------------------------------------------------------------
  // cleared at each start so a stale fault never leaks into the next command
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      tc_seen_q   <= 1'b0;
      end_track_q <= 1'b0;
      crc_any_q   <= 1'b0;
      overrun_q   <= 1'b0;
      sect_miss_q <= 1'b0;
      wr_block_q  <= 1'b0;
      id_sync_q   <= 1'b0;
      index_cnt_q <= `DRS_IDX_ZERO;
    end
    else if (exec_start && state_q == DRS_ST_IDLE)
    begin
      tc_seen_q   <= 1'b0;
      end_track_q <= 1'b0;
      crc_any_q   <= 1'b0;
      overrun_q   <= 1'b0;
      sect_miss_q <= 1'b0;
      wr_block_q  <= 1'b0;
      id_sync_q   <= 1'b0;
      index_cnt_q <= `DRS_IDX_ZERO;
    end
    else if (state_q == DRS_ST_EXEC)
    begin
      if (transfer_count_end)
        tc_seen_q <= 1'b1;
      if (sector_beyond || (cmd_done && fn_is_rw(cmd_q) && !tc_seen_q && !transfer_count_end))
        end_track_q <= 1'b1;
      if (crc_id_err || crc_data_err)
        crc_any_q <= 1'b1;
      if (xfer_overrun)
        overrun_q <= 1'b1;
      if (sector_not_found || (cmd_q == DRS_CMD_READ_ID && crc_id_err))
        sect_miss_q <= 1'b1;
      if (is_write && wp_in)
        wr_block_q <= 1'b1;
      // an id mark restarts the revolution count
      if (id_mark_found)
        index_cnt_q <= `DRS_IDX_ZERO;
      else if (rotation_marker_in && index_cnt_q != `DRS_INDEX_LIMIT)
        index_cnt_q <= index_cnt_q + `DRS_IDX_ONE;
      if ((!id_mark_found && index_cnt_q == `DRS_INDEX_LIMIT) || data_mark_missing)
        id_sync_q <= 1'b1;
    end
  end

  // byte 2 flags
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      ctrl_mark_q <= 1'b0;
      data_crc_q  <= 1'b0;
      trk_mism_q  <= 1'b0;
      bad_trk_q   <= 1'b0;
      data_sync_q <= 1'b0;
    end
    else if (exec_start && state_q == DRS_ST_IDLE)
    begin
      ctrl_mark_q <= 1'b0;
      data_crc_q  <= 1'b0;
      trk_mism_q  <= 1'b0;
      bad_trk_q   <= 1'b0;
      data_sync_q <= 1'b0;
    end
    else if (state_q == DRS_ST_EXEC)
    begin
      if (data_mark_found && is_read_data && (data_mark_deleted != (cmd_q == DRS_CMD_READ_DEL)))
        ctrl_mark_q <= 1'b1;
      if (crc_data_err)
        data_crc_q <= 1'b1;
      if (id_valid && id_track != internal_track)
      begin
        trk_mism_q <= 1'b1;
        if (id_track == `DRS_BAD_TRACK)
          bad_trk_q <= 1'b1;
      end
      if (data_mark_missing)
        data_sync_q <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // positioning outcome, held until sense-interrupt reports it
  // ----------------------------------------------------------------
  drs_seek_check u_seek_check
  (
    .core_clk       (core_clk),
    .rst            (rst),
    .recal_start    (exec_start && state_q == DRS_ST_IDLE && cmd_kind == DRS_CMD_RECAL),
    .step_pulse     (step_pulse),
    .home_track_in  (home_track_in),
    .relseek_start  (exec_start && state_q == DRS_ST_IDLE && cmd_kind == DRS_CMD_REL_SEEK),
    .seek_outward   (seek_outward),
    .seek_distance  (seek_distance),
    .internal_track (internal_track),
    .fault_q        (seek_fault)
  );

  // a completion in the same cycle as the report survives: set beats clear
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      pos_done_q   <= 1'b0;
      home_fault_q <= 1'b0;
    end
    else
    begin
      if (state_q == DRS_ST_EXEC && cmd_done && seek_cmd)
        pos_done_q <= 1'b1;
      else if (state_q == DRS_ST_EXEC && cmd_done && cmd_q == DRS_CMD_SENSE_INT)
        pos_done_q <= 1'b0;
      if (seek_fault)
        home_fault_q <= 1'b1;
      else if (state_q == DRS_ST_EXEC && cmd_done && cmd_q == DRS_CMD_SENSE_INT)
        home_fault_q <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // capture of the four bytes at completion
  // ----------------------------------------------------------------
  // frozen for the whole result phase so the host reads one consistent snapshot
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      st0_q     <= `DRS_BYTE_ZERO;
      st1_q     <= `DRS_BYTE_ZERO;
      st2_q     <= `DRS_BYTE_ZERO;
      st3_q     <= `DRS_BYTE_ZERO;
      res_cnt_q <= `DRS_CNT_ONE;
    end
    else if (state_q == DRS_ST_EXEC && cmd_done)
    begin
      st0_q[`DRS_ST0_CLASS_HI:`DRS_ST0_CLASS_LO] <= done_class;
      st0_q[`DRS_ST0_POS_DONE]   <= pos_done_q && cmd_q == DRS_CMD_SENSE_INT;
      st0_q[`DRS_ST0_HOME_FAULT] <= home_fault_q && cmd_q == DRS_CMD_SENSE_INT;
      st0_q[`DRS_ST0_ZERO]       <= 1'b0;
      st0_q[`DRS_ST0_HEAD]       <= head_addr;
      st0_q[`DRS_ST0_UNIT_HI:`DRS_ST0_UNIT_LO] <= drive_sel;
      st1_q <= {end_track_q || (fn_is_rw(cmd_q) && !tc_seen_q && !transfer_count_end), 1'b0,
                crc_any_q || crc_id_err || crc_data_err, overrun_q, 1'b0,
                sect_miss_q, wr_block_q, id_sync_q};
      st2_q <= {1'b0, ctrl_mark_q, data_crc_q, trk_mism_q, 2'b00, bad_trk_q, data_sync_q};
      st3_q <= {1'b0, wp_in, 1'b1, home_track_in, 1'b1, side_select_out, unit_select};
      res_cnt_q <= (cmd_q == DRS_CMD_SENSE_INT || cmd_q == DRS_CMD_SENSE_DRV || cmd_q == DRS_CMD_INVALID)
                   ? `DRS_CNT_ONE : `DRS_CNT_XFER;
    end
  end

  // ----------------------------------------------------------------
  // host read port
  // ----------------------------------------------------------------
  // reads outside the result phase are ignored; the host must wait for request and direction
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
      res_idx_q <= `DRS_IDX_ZERO;
    else if (state_q == DRS_ST_EXEC && cmd_done)
      res_idx_q <= `DRS_IDX_ZERO;
    else if (host_rd && state_q == DRS_ST_RESULT && !last_rd)
      res_idx_q <= res_idx_q + `DRS_IDX_ONE;
  end

  // output byte and handshake flags, all registered
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      result_data_q          <= `DRS_BYTE_ZERO;
      host_service_request_q <= 1'b1;
      transfer_direction_q   <= 1'b0;
      result_phase_q         <= 1'b0;
    end
    else
    begin
      if (state_q == DRS_ST_RESULT)
      begin
        // drive status answers with byte 3 alone
        if (cmd_q == DRS_CMD_SENSE_DRV)
          result_data_q <= st3_q;
        else
          result_data_q <= (res_idx_q == `DRS_IDX_ZERO) ? st0_q :
                           (res_idx_q == `DRS_IDX_ONE)  ? st1_q : st2_q;
      end
      else
        result_data_q <= `DRS_BYTE_ZERO;
      result_phase_q         <= (state_q == DRS_ST_RESULT) && !last_rd;
      transfer_direction_q   <= (state_q == DRS_ST_RESULT) && !last_rd;
      host_service_request_q <= (state_q == DRS_ST_RESULT) ? !last_rd : (state_q == DRS_ST_IDLE && !exec_start);
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  sequence s_host_read;
    host_rd && result_phase_q && state_q == DRS_ST_RESULT && !last_rd;
  endsequence

  property p_read_advance;
    @(posedge core_clk) disable iff (rst)
    s_host_read |=> (res_idx_q == $past(res_idx_q) + `DRS_IDX_ONE) ##1 result_phase_q;
  endproperty
  a_read_advance: assert property (p_read_advance) else $error("read did not advance");

  property p_class;
    @(posedge core_clk) disable iff (rst)
    state_q == DRS_ST_EXEC && cmd_done |=> st0_q[`DRS_ST0_CLASS_HI:`DRS_ST0_CLASS_LO] == $past(done_class);
  endproperty
  a_class: assert property (p_class) else $error("termination class wrong");

  property p_fixed_bits;
    @(posedge core_clk) disable iff (rst)
    !st0_q[`DRS_ST0_ZERO] && !st1_q[`DRS_ST1_ZERO_HI] && !st1_q[`DRS_ST1_ZERO_LO]
      && !st2_q[`DRS_ST2_ZERO_HI] && !st2_q[`DRS_ST2_ZERO_MID] && !st2_q[`DRS_ST2_ZERO_LO];
  endproperty
  a_fixed_bits: assert property (p_fixed_bits) else $error("zero bit set");

  property p_st3_fixed;
    @(posedge core_clk) disable iff (rst)
    state_q == DRS_ST_RESULT |-> !st3_q[`DRS_ST3_ZERO] && st3_q[`DRS_ST3_ONE_HI] && st3_q[`DRS_ST3_ONE_LO];
  endproperty
  a_st3_fixed: assert property (p_st3_fixed) else $error("byte 3 fixed bits wrong");

  property p_hold;
    @(posedge core_clk) disable iff (rst)
    state_q == DRS_ST_RESULT |=> $stable(st0_q) && $stable(st1_q) && $stable(st2_q) && $stable(st3_q);
  endproperty
  a_hold: assert property (p_hold) else $error("bytes changed in result phase");

  property p_wr_block;
    @(posedge core_clk) disable iff (rst)
    state_q == DRS_ST_EXEC && is_write && wp_in && !cmd_done |=> wr_block_q;
  endproperty
  a_wr_block: assert property (p_wr_block) else $error("write block flag missed");

  property p_trk_mism;
    @(posedge core_clk) disable iff (rst)
    state_q == DRS_ST_EXEC && id_valid && id_track == `DRS_BAD_TRACK && internal_track != `DRS_BAD_TRACK
      |=> trk_mism_q && bad_trk_q;
  endproperty
  a_trk_mism: assert property (p_trk_mism) else $error("bad track flags missed");

  property p_handshake;
    @(posedge core_clk) disable iff (rst)
    result_phase_q |-> host_service_request_q && transfer_direction_q;
  endproperty
  a_handshake: assert property (p_handshake) else $error("request or direction low");
endmodule : drs_result_status
`default_nettype wire

// >>> test/drs_host_model.sv
// host side model that reads result bytes from the data port
`timescale 1ns/1ps
`default_nettype none
module drs_host_model
(
  input  wire logic       core_clk,
  input  wire logic       rst,
  input  wire logic       clr,
  input  wire logic [7:0] result_data_q,
  input  wire logic       host_service_request_q,
  input  wire logic       transfer_direction_q,
  input  wire logic       result_phase_q,
  output logic            host_rd
);
  logic [7:0] got [0:3];
  int         n;
  int         gap;
  // read only on request with device-to-host direction; the gap lets the next byte land first
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      host_rd <= 1'b0;
      n       <= 0;
      gap     <= 0;
    end
    else
    begin
      host_rd <= 1'b0;
      if (gap > 0)
        gap <= gap - 1;
      if (clr)
        n <= 0;
      else if (gap == 0 && !host_rd && host_service_request_q && transfer_direction_q && result_phase_q)
      begin
        host_rd    <= 1'b1;
        got[n % 4] <= result_data_q;
        n          <= n + 1;
        gap        <= 3;
      end
    end
  end
endmodule : drs_host_model
`default_nettype wire

// >>> test/tb_top.sv
// self-checking bench for the result status byte encoder
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import drs_pkg::*;
  logic       core_clk, rst, exec_start, cmd_done, hd, home, wp, side, step, clr, id_v, mk, mk_del, so, idx;
  logic [1:0] dr, unit;
  logic [7:0] ev, rdata, sd;
  logic       rsr, dir, phase, host_rd;
  drs_cmd_e   kind;
  drs_class_e cls;
  int         error_cnt, check_count;

  drs_result_status u_dut (.core_clk(core_clk), .rst(rst), .exec_start(exec_start), .cmd_kind(kind),
    .cmd_done(cmd_done), .done_class(cls), .head_addr(hd), .drive_sel(dr), .step_pulse(step),
    .home_track_in(home), .seek_outward(so), .seek_distance(sd), .internal_track(8'h05),
    .transfer_count_end(ev[1]), .sector_beyond(ev[7]), .crc_id_err(ev[6]), .crc_data_err(ev[5]),
    .xfer_overrun(ev[4]), .sector_not_found(ev[3]), .wp_in(wp), .rotation_marker_in(idx),
    .id_mark_found(ev[0]), .data_mark_found(mk), .data_mark_deleted(mk_del), .data_mark_missing(ev[2]),
    .id_valid(id_v), .id_track(8'hff), .side_select_out(side), .unit_select(unit), .host_rd(host_rd),
    .result_data_q(rdata), .host_service_request_q(rsr), .transfer_direction_q(dir), .result_phase_q(phase));

  drs_host_model u_host (.core_clk(core_clk), .rst(rst), .clr(clr), .result_data_q(rdata),
    .host_service_request_q(rsr), .transfer_direction_q(dir), .result_phase_q(phase), .host_rd(host_rd));

  initial
  begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end

  task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk

  task automatic end_sim();
    $display("checks %0d errors %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : end_sim

  // start a command; clearing the model's count keeps byte slots per command
  task automatic start(input drs_cmd_e k);
    @(posedge core_clk) exec_start <= 1'b1;
    kind <= k;
    clr  <= 1'b1;
    @(posedge core_clk) exec_start <= 1'b0;
    clr <= 1'b0;
  endtask : start

  // end execution, then wait bounded for the host to drain n bytes
  task automatic finish(input drs_class_e c, input int n);
    @(posedge core_clk) cmd_done <= 1'b1;
    cls <= c;
    @(posedge core_clk) cmd_done <= 1'b0;
    repeat (40) @(posedge core_clk) if (u_host.n == n && !phase) break;
    repeat (4) @(posedge core_clk);
    chk("byte count", 8'(u_host.n), 8'(n));
    chk("idle flags", {5'h00, rsr, dir, phase}, 8'h04);
  endtask : finish

  // read with every fault event, a deleted mark and a bad track id
  task automatic t_read_faults();
    start(DRS_CMD_READ);
    @(posedge core_clk) ev <= 8'hff;
    @(posedge core_clk) ev <= 8'h00;
    mk     <= 1'b1;
    mk_del <= 1'b1;
    id_v   <= 1'b1;
    @(posedge core_clk) mk <= 1'b0;
    id_v <= 1'b0;
    finish(DRS_TC_ABORT, 3);
    chk("read byte0", u_host.got[0], {2'b01, 3'b000, hd, dr});
    chk("read byte1", u_host.got[1], 8'hb5);
    chk("read byte2", u_host.got[2], 8'h73);
  endtask : t_read_faults

  // write meets protect going high, two index pulses with no id mark, and no count end
  task automatic t_write_protect();
    start(DRS_CMD_WRITE);
    @(posedge core_clk) wp <= 1'b1;
    idx <= 1'b1;
    @(posedge core_clk) wp <= 1'b0;
    idx <= 1'b0;
    @(posedge core_clk) idx <= 1'b1;
    @(posedge core_clk) idx <= 1'b0;
    finish(DRS_TC_ABORT, 3);
    chk("write byte1", u_host.got[1], 8'h83);
    chk("write byte2", u_host.got[2], 8'h00);
  endtask : t_write_protect

  // drive status shows live pins with fixed ones and zero
  task automatic t_sense_drive();
    wp   <= 1'b1;
    home <= 1'b1;
    start(DRS_CMD_SENSE_DRV);
    finish(DRS_TC_NORMAL, 1);
    chk("drive byte3", u_host.got[0], 8'h7e);
    wp   <= 1'b0;
    home <= 1'b0;
  endtask : t_sense_drive

  // recalibrate never reaching home after 80 steps
  task automatic t_recal_fault();
    start(DRS_CMD_RECAL);
    repeat (80)
    begin
      @(posedge core_clk) step <= 1'b1;
      @(posedge core_clk) step <= 1'b0;
    end
    finish(DRS_TC_NORMAL, 0);
    start(DRS_CMD_SENSE_INT);
    finish(DRS_TC_NORMAL, 1);
    chk("recal byte0", u_host.got[0], {5'b00110, hd, dr});
  endtask : t_recal_fault

  // seek then sense interrupt with each termination class
  task automatic t_seek_classes();
    for (int c = 0; c < 4; c++)
    begin
      start(DRS_CMD_SEEK);
      finish(DRS_TC_NORMAL, 0);
      start(DRS_CMD_SENSE_INT);
      finish(drs_class_e'(c), 1);
      chk("seek byte0", u_host.got[0], {2'(c), 3'b100, hd, dr});
    end
  endtask : t_seek_classes

  // relative seek stepping outward past track zero, reported by sense interrupt
  task automatic t_relseek_fault();
    so <= 1'b1;
    sd <= 8'h09;
    start(DRS_CMD_REL_SEEK);
    so <= 1'b0;
    sd <= 8'h00;
    finish(DRS_TC_NORMAL, 0);
    start(DRS_CMD_SENSE_INT);
    finish(DRS_TC_NORMAL, 1);
    chk("relseek byte0", u_host.got[0], {5'b00110, hd, dr});
  endtask : t_relseek_fault

  // a command that cannot run answers with one byte of class invalid
  task automatic t_invalid();
    start(DRS_CMD_INVALID);
    finish(DRS_TC_INVALID, 1);
    chk("invalid byte0", u_host.got[0], {2'b10, 3'b000, hd, dr});
  endtask : t_invalid

  initial
  begin
    {rst, exec_start, cmd_done, home, wp, step, clr, id_v, mk, mk_del} = 10'b10_0000_0000;
    {hd, dr, side, unit, ev} = {1'b1, 2'b10, 1'b1, 2'b10, 8'h00};
    {so, idx, sd} = 10'h000;
    kind = DRS_CMD_OTHER;
    cls  = DRS_TC_NORMAL;
    repeat (6) @(posedge core_clk);
    rst <= 1'b0;
    @(negedge core_clk);
    chk("reset data", rdata, 8'h00);
    chk("reset flags", {5'h00, rsr, dir, phase}, 8'h04);
    t_read_faults();
    t_write_protect();
    t_sense_drive();
    t_recal_fault();
    t_seek_classes();
    t_relseek_fault();
    t_invalid();
    end_sim();
  end

  // watchdog well beyond the run's few hundred cycles
  initial
  begin
    #(50 * 4000);
    error_cnt++;
    end_sim();
  end
endmodule : tb_top
`default_nettype wire
